// >>> core/qed_defines.svh
`ifndef QED_DEFINES_SVH
`define QED_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define QED_OFF_SEL      12'h000
`define QED_OFF_CFG      12'h004
`define QED_OFF_CMD      12'h008
`define QED_OFF_HALT     12'h00C
`define QED_OFF_COUNT    12'h010
`define QED_OFF_STATUS   12'h014
`define QED_OFF_DEFSLOT  12'h018

////////////////////////////////////////////////////////////////////////////////
// field positions
`define QED_CMD_START    0
`define QED_CMD_STOP     1
`define QED_CMD_CLEAR    2
`define QED_ST_DIR       0
`define QED_ST_HALT      1
`define QED_ST_RUN       2
`define QED_ST_CFGD      3
`define QED_ST_ERR       8
`define QED_CFG_MSB      26
`define QED_SEL_MSB      3

////////////////////////////////////////////////////////////////////////////////
// field codes
`define QED_SLOT_DEFAULT 2'h0
`define QED_SLOT_4       2'h1
`define QED_SLOT_6       2'h2
`define QED_CHAN_OFF     4'h0
`define QED_CHAN_MAX     4'hE

////////////////////////////////////////////////////////////////////////////////
// reset values
`define QED_RST_SEL      4'h0
`define QED_RST_DEFSLOT  1'b0

////////////////////////////////////////////////////////////////////////////////
// timing
`define QED_CLK_KHZ      50000
`define QED_HALT_TIME_MS 50
`define QED_HALT_CYC     (`QED_HALT_TIME_MS * `QED_CLK_KHZ)

`endif

// >>> core/qed_pkg.sv
package qed_pkg;

    typedef struct packed {
        logic [1:0] kind;
        logic [3:0] unit;
        logic [3:0] chan;
        logic [1:0] slot;
        logic       trig_sel;
    } qed_src_t;

    typedef struct packed {
        logic     pol;
        qed_src_t b;
        qed_src_t a;
    } qed_cfg_t;

    typedef enum logic {
        QED_IDLE,
        QED_ANSWER
    } qed_apb_t;

endpackage

// >>> core/qed_core.sv
`timescale 1ns/10ps
`include "qed_defines.svh"

module qed_core
    import qed_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int TMR_W = 32
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // synchronised phases
    input  wire logic             phase_a,
    input  wire logic             phase_b,
    // control
    input  wire logic             start_pulse,
    input  wire logic             stop_pulse,
    input  wire logic             clear_pulse,
    input  wire logic             polarity,
    input  wire logic [TMR_W-1:0] halt_timeout,
    // state
    output logic      [CNT_W-1:0] count,
    output logic                  direction,
    output logic                  halted,
    output logic                  running
);

    typedef struct packed {
        logic             a_prev;
        logic             b_prev;
        logic             run;
        logic [CNT_W-1:0] cnt;
        logic             dir;
        logic             halt;
        logic [TMR_W-1:0] tmr;
    } qed_core_st_t;

    qed_core_st_t st_reg;
    qed_core_st_t st_next;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    always_comb begin
        logic a_chg;
        logic b_chg;
        logic a_lead;
        logic up;
        logic step;
        a_chg   = phase_a ^ st_reg.a_prev;
        b_chg   = phase_b ^ st_reg.b_prev;
        a_lead  = a_chg ? (phase_a ^ phase_b) : ~(phase_a ^ phase_b);
        up      = ~(a_lead ^ polarity);
        step    = st_reg.run && (a_chg ^ b_chg);
        st_next = st_reg;
        st_next.a_prev = phase_a;
        st_next.b_prev = phase_b;
        if (start_pulse) begin
            st_next.run = 1'b1;
        end
        if (stop_pulse) begin
            st_next.run = 1'b0;
        end
        if (step) begin
            st_next.cnt = up ? st_reg.cnt + CNT_W'(1) : st_reg.cnt - CNT_W'(1);
            st_next.dir = up;
        end
        if (clear_pulse) begin
            st_next.cnt = '0;
        end
        if (a_chg || b_chg || clear_pulse) begin
            st_next.tmr  = '0;
            st_next.halt = 1'b0;
        end else if (st_reg.tmr >= halt_timeout) begin
            st_next.halt = 1'b1;
        end else begin
            st_next.tmr = st_reg.tmr + TMR_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count     = st_reg.cnt;
    assign direction = st_reg.dir;
    assign halted    = st_reg.halt;
    assign running   = st_reg.run;

endmodule

// >>> core/qed_top.sv
`timescale 1ns/10ps
`include "qed_defines.svh"

// Functional notes
// - polarity true: A leading B counts up
// - polarity false default: B leading counts up
// - source bit picks trigger or digital input
// - digital channel numbers 1 through 14
// - disabled channel reads constant zero
// - slot 4 or 6; default slot configurable
// - trigger unit 0..7, bad index errors
// - clear command zeroes addressed count
// - instance 0..7, bad index errors on config, command, halt and count (status reads zero bits, no error), only the error flag changes
// - start/stop gate decoding; stopped count holds until a clear
// - every single-phase edge counts, four per cycle; both phases changing together does not count
// - direction flag follows last counted step, not clear
// - halted after timeout without phase edge or clear
module qed_top
    import qed_pkg::*;
#(
    parameter int unsigned HALT_CYC = `QED_HALT_CYC,
    parameter int          INST_N   = 8,
    parameter int          CHAN_N   = 14,
    parameter int          TRIG_W   = 32
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // phase sources
    input  wire logic [CHAN_N-1:0] dig_slot4_in,
    input  wire logic [CHAN_N-1:0] dig_slot6_in,
    input  wire logic [TRIG_W-1:0] trig_out_in
);

    typedef struct packed {
        qed_apb_t                fsm;
        logic                    pready;
        logic                    pslverr;
        logic [31:0]             prdata;
        logic [3:0]              sel;
        logic                    defslot;
        logic                    err;
        logic [INST_N-1:0]       cfgd;
        qed_cfg_t [INST_N-1:0]   cfg;
        logic [INST_N-1:0][31:0] halt_to;
        logic [INST_N-1:0]       start_p;
        logic [INST_N-1:0]       stop_p;
        logic [INST_N-1:0]       clr_p;
        logic [CHAN_N-1:0]       d4_s1;
        logic [CHAN_N-1:0]       d4_s2;
        logic [CHAN_N-1:0]       d6_s1;
        logic [CHAN_N-1:0]       d6_s2;
        logic [TRIG_W-1:0]       tr_s1;
        logic [TRIG_W-1:0]       tr_s2;
    } qed_top_st_t;

    qed_top_st_t             st_reg;
    qed_top_st_t             st_next;
    logic [INST_N-1:0][31:0] cnt_w;
    logic [INST_N-1:0]       dir_w;
    logic [INST_N-1:0]       halt_w;
    logic [INST_N-1:0]       run_w;

    // one-hot positions of the register decode
    localparam int HIT_SEL  = 0;
    localparam int HIT_CFG  = 1;
    localparam int HIT_CMD  = 2;
    localparam int HIT_HALT = 3;
    localparam int HIT_CNT  = 4;
    localparam int HIT_STAT = 5;
    localparam int HIT_DEF  = 6;

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [6:0] reg_hit(logic [11:0] a);
        logic [6:0] h;
        h = 7'h00;
        case (a)
            `QED_OFF_SEL: begin
                h[HIT_SEL] = 1'b1;
            end
            `QED_OFF_CFG: begin
                h[HIT_CFG] = 1'b1;
            end
            `QED_OFF_CMD: begin
                h[HIT_CMD] = 1'b1;
            end
            `QED_OFF_HALT: begin
                h[HIT_HALT] = 1'b1;
            end
            `QED_OFF_COUNT: begin
                h[HIT_CNT] = 1'b1;
            end
            `QED_OFF_STATUS: begin
                h[HIT_STAT] = 1'b1;
            end
            `QED_OFF_DEFSLOT: begin
                h[HIT_DEF] = 1'b1;
            end
            default: begin
                h = 7'h00;
            end
        endcase
        return h;
    endfunction

    function automatic logic src_ok(qed_src_t s);
        logic ok;
        ok = 1'b1;
        if (s.trig_sel) begin
            ok = (s.unit[3] == 1'b0);
        end else begin
            ok = (s.slot != 2'h3) && (s.chan <= `QED_CHAN_MAX);
        end
        return ok;
    endfunction

    function automatic logic phase_pick(qed_src_t s, logic defslot, logic [CHAN_N-1:0] d4,
                                        logic [CHAN_N-1:0] d6, logic [TRIG_W-1:0] tr);
        logic              six;
        logic [CHAN_N-1:0] bank;
        logic              v;
        six  = (s.slot == `QED_SLOT_6) || ((s.slot == `QED_SLOT_DEFAULT) && defslot);
        bank = six ? d6 : d4;
        if (s.trig_sel) begin
            v = tr[{s.unit[2:0], s.kind}];
        end else if (s.chan == `QED_CHAN_OFF || s.chan > `QED_CHAN_MAX) begin
            v = 1'b0;
        end else begin
            v = bank[s.chan - 4'h1];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [2:0]  idx;
        logic        inst_ok;
        logic        bad;
        logic [31:0] rd;
        qed_cfg_t    wcfg;
        logic [6:0]  hit;
        idx     = st_reg.sel[2:0];
        inst_ok = !st_reg.sel[`QED_SEL_MSB];
        bad     = 1'b0;
        rd      = 32'h0;
        wcfg    = qed_cfg_t'(pwdata[`QED_CFG_MSB:0]);
        hit     = reg_hit(paddr);
        st_next = st_reg;
        st_next.start_p = '0;
        st_next.stop_p  = '0;
        st_next.clr_p   = '0;
        st_next.d4_s1   = dig_slot4_in;
        st_next.d4_s2   = st_reg.d4_s1;
        st_next.d6_s1   = dig_slot6_in;
        st_next.d6_s2   = st_reg.d6_s1;
        st_next.tr_s1   = trig_out_in;
        st_next.tr_s2   = st_reg.tr_s1;
        case (1'b1)
            hit[HIT_SEL]: begin
                rd = {28'h0, st_reg.sel};
            end
            hit[HIT_CFG]: begin
                rd  = {5'h0, st_reg.cfg[idx]};
                bad = !inst_ok || (pwrite && !(src_ok(wcfg.a) && src_ok(wcfg.b)));
            end
            hit[HIT_CMD]: begin
                bad = !inst_ok;
            end
            hit[HIT_HALT]: begin
                rd  = st_reg.halt_to[idx];
                bad = !inst_ok;
            end
            hit[HIT_CNT]: begin
                rd  = cnt_w[idx];
                bad = !inst_ok;
            end
            hit[HIT_STAT]: begin
                rd = {23'h0, st_reg.err, 4'h0,
                      inst_ok & st_reg.cfgd[idx], inst_ok & run_w[idx],
                      inst_ok & halt_w[idx], inst_ok & dir_w[idx]};
            end
            hit[HIT_DEF]: begin
                rd = {31'h0, st_reg.defslot};
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        if (bad) begin
            rd = 32'h0;
        end
        case (st_reg.fsm)
            QED_IDLE: begin
                if (psel && penable) begin
                    st_next.pready  = 1'b1;
                    st_next.pslverr = bad;
                    st_next.prdata  = pwrite ? 32'h0 : rd;
                    st_next.fsm     = QED_ANSWER;
                end
            end
            QED_ANSWER: begin
                st_next.pready  = 1'b0;
                st_next.pslverr = 1'b0;
                st_next.fsm     = QED_IDLE;
                if (pwrite && !st_reg.pslverr) begin
                    case (1'b1)
                        hit[HIT_SEL]: begin
                            st_next.sel = pwdata[3:0];
                        end
                        hit[HIT_CFG]: begin
                            st_next.cfg[idx]  = wcfg;
                            st_next.cfgd[idx] = 1'b1;
                        end
                        hit[HIT_CMD]: begin
                            st_next.start_p[idx] = pwdata[`QED_CMD_START];
                            st_next.stop_p[idx]  = pwdata[`QED_CMD_STOP];
                            st_next.clr_p[idx]   = pwdata[`QED_CMD_CLEAR];
                        end
                        hit[HIT_HALT]: begin
                            st_next.halt_to[idx] = pwdata;
                        end
                        hit[HIT_CNT]: begin
                            // count is read-only, writes ignored
                            st_next.err = st_reg.err;
                        end
                        hit[HIT_STAT]: begin
                            st_next.err = st_reg.err & ~pwdata[`QED_ST_ERR];
                        end
                        hit[HIT_DEF]: begin
                            st_next.defslot = pwdata[0];
                        end
                        default: begin
                            st_next.err = st_reg.err;
                        end
                    endcase
                end
                if (st_reg.pslverr) begin
                    st_next.err = 1'b1;
                end
            end
            default: begin
                st_next.fsm    = QED_IDLE;
                st_next.pready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg         <= '0;
            st_reg.sel     <= `QED_RST_SEL;
            st_reg.defslot <= `QED_RST_DEFSLOT;
            st_reg.halt_to <= {INST_N{32'(HALT_CYC)}};
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoder instances
    generate
        for (genvar i = 0; i < INST_N; i++) begin : g_inst
            logic pa;
            logic pb;
            assign pa = phase_pick(st_reg.cfg[i].a, st_reg.defslot, st_reg.d4_s2, st_reg.d6_s2, st_reg.tr_s2);
            assign pb = phase_pick(st_reg.cfg[i].b, st_reg.defslot, st_reg.d4_s2, st_reg.d6_s2, st_reg.tr_s2);
            qed_core #(
                .CNT_W (32),
                .TMR_W (32)
            ) u_core (
                .pclk         (pclk),
                .presetn      (presetn),
                .phase_a      (pa),
                .phase_b      (pb),
                .start_pulse  (st_reg.start_p[i]),
                .stop_pulse   (st_reg.stop_p[i]),
                .clear_pulse  (st_reg.clr_p[i]),
                .polarity     (st_reg.cfg[i].pol),
                .halt_timeout (st_reg.halt_to[i]),
                .count        (cnt_w[i]),
                .direction    (dir_w[i]),
                .halted       (halt_w[i]),
                .running      (run_w[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata  = st_reg.prdata;
    assign pready  = st_reg.pready;
    assign pslverr = st_reg.pslverr;

endmodule

// >>> dv/qed_top_asserts.sv
`timescale 1ns/10ps
`include "qed_defines.svh"
module qed_top_asserts #(
    parameter int CHAN_N = 14,
    parameter int TRIG_W = 32
) (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // phases
    input wire logic [CHAN_N-1:0] dig_slot4_in,
    input wire logic [CHAN_N-1:0] dig_slot6_in,
    input wire logic [TRIG_W-1:0] trig_out_in
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic sel_bad_reg;
    wire logic cfg_w = pwrite && paddr == `QED_OFF_CFG;
    // last accepted instance index out of range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_bad_reg <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == `QED_OFF_SEL) begin
            sel_bad_reg <= pwdata[3];
        end
    end
    sequence s_req(cond);
        psel && !penable ##1 psel && penable && !pready && cond;
    endsequence
    answer_delay_a: assert property (s_req(1'b1) |=> pready)
        else $error("no answer after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_qualify_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    write_data_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on write answer");
    data_hold_a: assert property (!pready |-> $stable(prdata))
        else $error("read data moved outside answer");
    unmapped_err_a: assert property (s_req(paddr > `QED_OFF_DEFSLOT || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped access accepted");
    bad_unit_a: assert property (s_req(cfg_w && (pwdata[0] && pwdata[10] || pwdata[13] && pwdata[23])) |=> pslverr)
        else $error("trigger unit above range accepted");
    bad_chan_a: assert property (s_req(cfg_w && !pwdata[0] && pwdata[6:3] == 4'hF) |=> pslverr)
        else $error("channel above range accepted");
    bad_slot_a: assert property (s_req(cfg_w && !pwdata[0] && pwdata[2:1] == 2'h3) |=> pslverr)
        else $error("bad slot accepted");
    bad_inst_a: assert property (s_req(sel_bad_reg && paddr == `QED_OFF_CMD) |=> pslverr)
        else $error("command to bad instance accepted");
    sel_ok_a: assert property (s_req(paddr == `QED_OFF_SEL) |=> !pslverr)
        else $error("instance select refused");
endmodule
bind qed_top qed_top_asserts #(.CHAN_N(CHAN_N), .TRIG_W(TRIG_W)) u_asserts (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dig_slot4_in(dig_slot4_in), .dig_slot6_in(dig_slot6_in),
    .trig_out_in(trig_out_in));

// >>> dv/qed_enc_model.sv
`timescale 1ns/10ps
module qed_enc_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // step request
    input  wire logic step,
    input  wire logic back,
    // phases
    output logic      pha,
    output logic      phb
);
    logic [1:0] pos_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_reg <= 2'h0;
        end else if (step) begin
            pos_reg <= back ? pos_reg - 2'h1 : pos_reg + 2'h1;
        end
    end
    // forward motion: a leads b
    assign pha = pos_reg[1] ^ pos_reg[0];
    assign phb = pos_reg[1];
endmodule

// >>> dv/testbench.sv
`timescale 1ns/10ps
`include "qed_defines.svh"
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, noise = 32'h0;
    logic        pready, pslverr, pha, phb, step = 1'b0, back = 1'b0, dir = 1'b0;
    logic [1:0]  pos = 2'h0;
    logic [31:0] qd[$];
    logic        qe[$];
    int          n_errors = 0, samples_checked = 0, cnt = 0;
    logic [12:0] srca[6] = '{13'h00A, 13'h008, 13'h01C, 13'h018, 13'h381, 13'h002};
    logic [12:0] srcb[6] = '{13'h012, 13'h010, 13'h024, 13'h020, 13'hB81, 13'h012};
    always #10 pclk = ~pclk;
    qed_top #(.HALT_CYC(50)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dig_slot4_in({noise[13:2], phb, pha}), .dig_slot6_in({noise[13:4], phb, pha, noise[1:0]}),
        .trig_out_in({noise[31:30], phb, pha, noise[27:0]}));
    qed_enc_model ENC (.pclk(pclk), .presetn(presetn), .step(step), .back(back), .pha(pha), .phb(phb));
    ////////////////////////////////////////
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // answers are compared against the oldest note
    always @(negedge pclk) begin
        if (pready === 1'b1) begin
            check("prdata", prdata, qd.pop_front());
            check("pslverr", {31'h0, pslverr}, {31'h0, qe.pop_front()});
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp, input logic err);
        qd.push_back(exp);
        qe.push_back(err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, 32'h0, err);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0, exp, err);
    endtask
    // one encoder step; reference count from the phases the decoder sees
    task mv(input logic bk, input logic da, input logic pol, input logic run);
        logic [1:0] i0;
        logic [1:0] dd;
        i0 = da ? {2{pos[1]}} : pos;
        pos = bk ? pos - 2'h1 : pos + 2'h1;
        dd = (da ? {2{pos[1]}} : pos) - i0;
        step <= 1'b1;
        back <= bk;
        @(posedge pclk);
        step <= 1'b0;
        if (run && dd[0]) begin
            dir = dd[1] ^ pol;
            cnt = dir ? cnt + 1 : cnt - 1;
        end
        repeat ($urandom_range(3, 1)) @(posedge pclk);
    endtask
    task test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        test_done();
    end
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h33B8));
        noise <= $urandom();
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`QED_OFF_STATUS, 32'h0, 1'b0);
        rd(`QED_OFF_HALT, 32'd50, 1'b0);
        rd(`QED_OFF_CFG, 32'h0, 1'b0);
        $display("test reset done");
        wr(`QED_OFF_HALT, 32'h000F_FFFF, 1'b0);
        for (int i = 0; i < 12; i++) begin
            wr(`QED_OFF_DEFSLOT, {31'h0, i / 2 == 3}, 1'b0);
            wr(`QED_OFF_CFG, {5'h0, i[0], srcb[i/2], srca[i/2]}, 1'b0);
            wr(`QED_OFF_CMD, 32'h5, 1'b0);
            cnt = 0;
            repeat (12) mv($urandom_range(1, 0) == 1, i / 2 == 5, i[0], 1'b1);
            repeat (3) @(posedge pclk);
            rd(`QED_OFF_COUNT, 32'(cnt), 1'b0);
            rd(`QED_OFF_STATUS, {28'h0, 3'h6, dir}, 1'b0);
        end
        $display("test decode done");
        wr(`QED_OFF_CMD, 32'h2, 1'b0);
        repeat (6) mv(1'b0, 1'b1, 1'b1, 1'b0);
        rd(`QED_OFF_COUNT, 32'(cnt), 1'b0);
        wr(`QED_OFF_HALT, 32'd20, 1'b0);
        repeat (25) @(posedge pclk);
        rd(`QED_OFF_STATUS, {28'h0, 3'h5, dir}, 1'b0);
        wr(`QED_OFF_CMD, 32'h4, 1'b0);
        rd(`QED_OFF_COUNT, 32'h0, 1'b0);
        wr(`QED_OFF_CMD, 32'h5, 1'b0);
        cnt = 0;
        mv(1'b0, 1'b1, 1'b1, 1'b1);
        rd(`QED_OFF_STATUS, {28'h0, 3'h6, dir}, 1'b0);
        $display("test stop and halt done");
        wr(`QED_OFF_CFG, 32'h0000_0401, 1'b1);
        wr(`QED_OFF_CFG, 32'h0000_000E, 1'b1);
        wr(`QED_OFF_CFG, 32'h0000_007A, 1'b1);
        rd(`QED_OFF_CFG, {5'h0, 1'b1, 13'h012, 13'h002}, 1'b0);
        rd(12'h01C, 32'h0, 1'b1);
        wr(`QED_OFF_SEL, 32'h8, 1'b0);
        wr(`QED_OFF_CMD, 32'h4, 1'b1);
        rd(`QED_OFF_COUNT, 32'h0, 1'b1);
        rd(`QED_OFF_STATUS, 32'h100, 1'b0);
        wr(`QED_OFF_SEL, 32'h0, 1'b0);
        rd(`QED_OFF_COUNT, 32'(cnt), 1'b0);
        wr(`QED_OFF_STATUS, 32'h100, 1'b0);
        rd(`QED_OFF_STATUS, {28'h0, 3'h7, dir}, 1'b0);
        $display("test errors done");
        test_done();
    end
endmodule
